// ==== pbl_pkg.sv ====
// Constants, register map and carrier types for the panel button/lamp block.
// Assumes a 100 MHz system clock and an AXI4-Lite register slave.
package pbl_pkg;
  localparam int unsigned NUM_BTN = 4;
  localparam int unsigned NUM_IND = 6;
  localparam int unsigned ADDR_W  = 8;

  // Byte offsets of the registers
  localparam logic [7:0] OFS_LATCH_SEL = 8'h00;
  localparam logic [7:0] OFS_SEPARATE  = 8'h04;
  localparam logic [7:0] OFS_PRESSED   = 8'h08;
  localparam logic [7:0] OFS_FORCE_EQ  = 8'h0C;
  localparam logic [7:0] OFS_FORCE_OR  = 8'h10;
  localparam logic [7:0] OFS_FORCE_AND = 8'h14;
  localparam logic [7:0] OFS_BTN_ON    = 8'h18;
  localparam logic [7:0] OFS_BTN_FLASH = 8'h1C;
  localparam logic [7:0] OFS_IND_ON    = 8'h20;
  localparam logic [7:0] OFS_IND_FLASH = 8'h24;

  // Force word: low nibble carries values, next nibble selects buttons
  localparam int unsigned FORCE_SEL_LSB = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Flash half period
  localparam int unsigned FLASH_HALF_MS  = 250;
  localparam int unsigned CLK_KHZ        = 100000;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    PBL_FORCE_NONE = 2'h0,
    PBL_FORCE_EQ   = 2'h1,
    PBL_FORCE_OR   = 2'h3,
    PBL_FORCE_AND  = 2'h2
  } pbl_force_op_t;

  // One force command toward the button logic
  typedef struct packed {
    pbl_force_op_t            op;
    logic [NUM_BTN-1:0]       sel;
    logic [NUM_BTN-1:0]       val;
  } pbl_force_t;

  // Host lamp control for one lamp group
  typedef struct packed {
    logic [NUM_IND-1:0] on;
    logic [NUM_IND-1:0] flash;
  } pbl_lamp_ctl_t;
endpackage

// ==== pbl_flash_div.sv ====
// Free-running divider giving a square flash phase for every lamp.
// Assumes one system clock; the phase is shared so lamps blink together.
module pbl_flash_div #(
  parameter int unsigned HALF_CYC = pbl_pkg::FLASH_HALF_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      phase_q
);
  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          phase_d;

  // Count one half period, then flip the phase
  always_comb begin
    cnt_d   = cnt_q + CW'(1);
    phase_d = phase_q;
    if (cnt_q >= LAST) begin
      cnt_d   = '0;
      phase_d = ~phase_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end
endmodule

// ==== pbl_button.sv ====
// Per-button state: momentary follow or alternate latch, plus host forces.
// Assumes press input already synchronised to aclk.
module pbl_button (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              latch_sel,
  input  wire logic              press,
  input  wire pbl_pkg::pbl_force_op_t op,
  input  wire logic              val,
  output logic                   state_q
);
  logic press_q;
  logic state_d;

  // Latch toggles on press edge; force acts only in latch mode
  always_comb begin
    state_d = state_q;
    if (!latch_sel) begin
      state_d = press;
    end else begin
      if (press && !press_q) begin
        state_d = ~state_q;
      end
      case (op)
        pbl_pkg::PBL_FORCE_EQ:  state_d = val;
        pbl_pkg::PBL_FORCE_OR:  state_d = state_q | val;
        pbl_pkg::PBL_FORCE_AND: state_d = ~(state_q & val);
        default:                state_d = state_d;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      press_q <= 1'b0;
      state_q <= 1'b0;
    end else begin
      press_q <= press;
      state_q <= state_d;
    end
  end
endmodule

// ==== pbl_panel.sv ====
// Operator panel top: AXI4-Lite registers, four buttons, lamp drive.
// Assumes raw button pins from outside; host on AXI4-Lite at aclk.
// Operation
// - Each button selects latching alternate action or momentary follow.
// - Latch selects are read/write; pressed state follows selected mode.
// - Assign force sets button state to supplied value; the code applies it only to buttons in latch mode.
// - OR force sets state to present state OR supplied value; the code applies it only to buttons in latch mode.
// - AND force sets state to NOT(present state AND value); the code applies it only to buttons in latch mode.
// - Read-only pressed flag reported for each of four buttons.
// - Separation bit read/write; when set host owns button lamps.
// - Write-only host on control per button lamp, used under separation.
// - Write-only host flash per button lamp, needs on and separation.
// - Six indicator lamps each switched by write-only on control.
// - Indicator flashes when flash set, only while its on is set.
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
module pbl_panel #(
  parameter int unsigned FLASH_HALF_CYC = pbl_pkg::FLASH_HALF_CYC
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [pbl_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [pbl_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic [pbl_pkg::NUM_BTN-1:0]  button_press,
  output logic [pbl_pkg::NUM_BTN-1:0]       button_lamp_q,
  output logic [pbl_pkg::NUM_IND-1:0]       indicator_lamp_q
);
  localparam int unsigned NB = pbl_pkg::NUM_BTN;
  localparam int unsigned NI = pbl_pkg::NUM_IND;

  // Write channel state
  logic                  aw_held_q, aw_held_d;
  logic [7:0]            aw_addr_q, aw_addr_d;
  logic                  w_held_q, w_held_d;
  logic [31:0]           w_data_q, w_data_d;
  logic                  w_strb0_q, w_strb0_d;
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q, bresp_d;
  // Read channel state
  logic                  rvalid_q, rvalid_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [1:0]            rresp_q, rresp_d;
  // Control registers
  logic [NB-1:0]         latch_sel_q, latch_sel_d;
  logic                  separate_q, separate_d;
  logic [NB-1:0]         btn_on_q, btn_on_d;
  logic [NB-1:0]         btn_flash_q, btn_flash_d;
  pbl_pkg::pbl_lamp_ctl_t ind_q, ind_d;
  pbl_pkg::pbl_force_t   force_q, force_d;
  // Lamp outputs
  logic [NB-1:0]         btn_lamp_d;
  logic [NI-1:0]         ind_lamp_d;
  // Pin synchroniser and button states
  logic [NB-1:0]         press_meta_q, press_sync_q;
  logic [NB-1:0]         pressed;
  logic                  phase;
  logic                  do_write;
  logic                  awready_q, awready_d;
  logic                  wready_q, wready_d;
  logic                  arready_q, arready_d;

  // True for every mapped offset; reused by both channels
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      pbl_pkg::OFS_LATCH_SEL, pbl_pkg::OFS_SEPARATE, pbl_pkg::OFS_PRESSED,
      pbl_pkg::OFS_FORCE_EQ, pbl_pkg::OFS_FORCE_OR, pbl_pkg::OFS_FORCE_AND,
      pbl_pkg::OFS_BTN_ON, pbl_pkg::OFS_BTN_FLASH, pbl_pkg::OFS_IND_ON,
      pbl_pkg::OFS_IND_FLASH: is_mapped = 1'b1;
      default:                is_mapped = 1'b0;
    endcase
  endfunction

  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  // Write path: address and data taken in either order, then response
  always_comb begin
    aw_held_d   = aw_held_q;
    aw_addr_d   = aw_addr_q;
    w_held_d    = w_held_q;
    w_data_d    = w_data_q;
    w_strb0_d   = w_strb0_q;
    bvalid_d    = bvalid_q;
    bresp_d     = bresp_q;
    latch_sel_d = latch_sel_q;
    separate_d  = separate_q;
    btn_on_d    = btn_on_q;
    btn_flash_d = btn_flash_q;
    ind_d       = ind_q;
    force_d     = '0;  // Force is a one-cycle command
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      aw_addr_d = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d  = 1'b1;
      w_data_d  = s_axi_wdata;
      w_strb0_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = is_mapped(aw_addr_q) ? pbl_pkg::RESP_OKAY
                                       : pbl_pkg::RESP_SLVERR;
      // Only the low lane holds fields, so only its strobe matters
      if (w_strb0_q) begin
        case (aw_addr_q)
          pbl_pkg::OFS_LATCH_SEL: latch_sel_d = w_data_q[NB-1:0];
          pbl_pkg::OFS_SEPARATE:  separate_d  = w_data_q[0];
          pbl_pkg::OFS_BTN_ON:    btn_on_d    = w_data_q[NB-1:0];
          pbl_pkg::OFS_BTN_FLASH: btn_flash_d = w_data_q[NB-1:0];
          pbl_pkg::OFS_IND_ON:    ind_d.on    = w_data_q[NI-1:0];
          pbl_pkg::OFS_IND_FLASH: ind_d.flash = w_data_q[NI-1:0];
          pbl_pkg::OFS_FORCE_EQ: begin
            force_d.op  = pbl_pkg::PBL_FORCE_EQ;
            force_d.val = w_data_q[NB-1:0];
            force_d.sel = w_data_q[pbl_pkg::FORCE_SEL_LSB +: NB];
          end
          pbl_pkg::OFS_FORCE_OR: begin
            force_d.op  = pbl_pkg::PBL_FORCE_OR;
            force_d.val = w_data_q[NB-1:0];
            force_d.sel = w_data_q[pbl_pkg::FORCE_SEL_LSB +: NB];
          end
          pbl_pkg::OFS_FORCE_AND: begin
            force_d.op  = pbl_pkg::PBL_FORCE_AND;
            force_d.val = w_data_q[NB-1:0];
            force_d.sel = w_data_q[pbl_pkg::FORCE_SEL_LSB +: NB];
          end
          default: force_d = '0;
        endcase
      end
    end
    // Readies registered from next state so each port leaves a flop
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
  end

  // Read path: one read at a time, data from registers
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = '0;
      rresp_d  = pbl_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        pbl_pkg::OFS_LATCH_SEL: rdata_d[NB-1:0] = latch_sel_q;
        pbl_pkg::OFS_SEPARATE:  rdata_d[0]      = separate_q;
        pbl_pkg::OFS_PRESSED:   rdata_d[NB-1:0] = pressed;
        default: begin
          // Write-only controls read as zero
          if (!is_mapped({s_axi_araddr[7:2], 2'b00})) begin
            rresp_d = pbl_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Lamp drive: host owns button lamps only under separation
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      if (separate_q) begin
        btn_lamp_d[i] = btn_on_q[i] && (!btn_flash_q[i] || phase);
      end else begin
        btn_lamp_d[i] = pressed[i];
      end
    end
    for (int j = 0; j < NI; j++) begin
      ind_lamp_d[j] = ind_q.on[j] && (!ind_q.flash[j] || phase);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q        <= 1'b0;
      aw_addr_q        <= '0;
      w_held_q         <= 1'b0;
      w_data_q         <= '0;
      w_strb0_q        <= 1'b0;
      bvalid_q         <= 1'b0;
      bresp_q          <= pbl_pkg::RESP_OKAY;
      rvalid_q         <= 1'b0;
      rdata_q          <= '0;
      rresp_q          <= pbl_pkg::RESP_OKAY;
      latch_sel_q      <= '0;
      separate_q       <= 1'b0;
      btn_on_q         <= '0;
      btn_flash_q      <= '0;
      ind_q            <= '0;
      force_q          <= '0;
      button_lamp_q    <= '0;
      indicator_lamp_q <= '0;
      press_meta_q     <= '0;
      press_sync_q     <= '0;
      awready_q        <= 1'b0;
      wready_q         <= 1'b0;
      arready_q        <= 1'b0;
    end else begin
      aw_held_q        <= aw_held_d;
      aw_addr_q        <= aw_addr_d;
      w_held_q         <= w_held_d;
      w_data_q         <= w_data_d;
      w_strb0_q        <= w_strb0_d;
      bvalid_q         <= bvalid_d;
      bresp_q          <= bresp_d;
      rvalid_q         <= rvalid_d;
      rdata_q          <= rdata_d;
      rresp_q          <= rresp_d;
      latch_sel_q      <= latch_sel_d;
      separate_q       <= separate_d;
      btn_on_q         <= btn_on_d;
      btn_flash_q      <= btn_flash_d;
      ind_q            <= ind_d;
      force_q          <= force_d;
      button_lamp_q    <= btn_lamp_d;
      indicator_lamp_q <= ind_lamp_d;
      press_meta_q     <= button_press;
      press_sync_q     <= press_meta_q;
      awready_q        <= awready_d;
      wready_q         <= wready_d;
      arready_q        <= arready_d;
    end
  end

  // Handshake outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  pbl_flash_div #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .phase_q (phase)
  );

  // One state machine per button; forces only reach selected buttons
  for (genvar g = 0; g < NB; g++) begin : g_btn
    pbl_button u_btn (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .latch_sel (latch_sel_q[g]),
      .press     (press_sync_q[g]),
      .op        (force_q.sel[g] ? force_q.op : pbl_pkg::PBL_FORCE_NONE),
      .val       (force_q.val[g]),
      .state_q   (pressed[g])
    );
  end

  // Checks beside the logic
  a_momentary_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!latch_sel_q[0] && $stable(latch_sel_q[0]))
      |=> pressed[0] == $past(press_sync_q[0]))
    else $error("momentary button does not follow press");
  a_force_equal: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (force_q.op == pbl_pkg::PBL_FORCE_EQ && force_q.sel[0] && latch_sel_q[0])
      |=> pressed[0] == $past(force_q.val[0]))
    else $error("assign force not applied");
  a_force_or: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (force_q.op == pbl_pkg::PBL_FORCE_OR && force_q.sel[0] &&
     force_q.val[0] && latch_sel_q[0]) |=> pressed[0])
    else $error("or force did not press");
  a_force_and: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (force_q.op == pbl_pkg::PBL_FORCE_AND && force_q.sel[0] &&
     latch_sel_q[0]) |=> pressed[0] == !($past(pressed[0]) &&
     $past(force_q.val[0])))
    else $error("and force wrong");
  a_sep_lamp: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!separate_q) |=> button_lamp_q[0] == $past(pressed[0]))
    else $error("button lamp not showing pressed state");
  a_host_lamp_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (separate_q && !btn_on_q[1]) |=> !button_lamp_q[1])
    else $error("button lamp lit without on control");
  a_ind_steady: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!ind_q.flash[2]) |=> indicator_lamp_q[2] == $past(ind_q.on[2]))
    else $error("indicator not steady");
  a_ind_flash: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ind_q.on[0] && ind_q.flash[0]) |=> indicator_lamp_q[0] == $past(phase))
    else $error("indicator not flashing with phase");
  a_write_resp: assert property (
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write response missing");
  a_read_pressed: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == pbl_pkg::OFS_PRESSED)
      |=> s_axi_rdata[NB-1:0] == $past(pressed))
    else $error("pressed read wrong");
endmodule

// ==== pbl_pin_model.sv ====
// Pin model of the four panel pushbuttons seen from outside the block.
// Assumes the bench sets the wanted key pattern just after a rising edge.
module pbl_pin_model (
  input  wire logic                        aclk,
  input  wire logic [pbl_pkg::NUM_BTN-1:0] want,
  input  wire logic                        slow,
  output logic [pbl_pkg::NUM_BTN-1:0]      button_press
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_q = 3'h0;

  // Slow mode lands a change four cycles late, like a stiff key
  always @(posedge aclk) begin
    if (want !== button_press && slow && wait_q != 3'h4) begin
      wait_q <= wait_q + 3'h1;
    end else begin
      wait_q       <= 3'h0;
      button_press <= want; // Level held while pressed
    end
  end

  initial button_press = '0;
endmodule

// ==== pbl_panel_test.sv ====
// Self-checking bench for the panel button and lamp block.
// Assumes the design package is compiled first; one 100 MHz clock.
module pbl_panel_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HALF = 8;
  localparam logic [1:0]  OK = pbl_pkg::RESP_OKAY;
  localparam logic [1:0]  SE = pbl_pkg::RESP_SLVERR;

  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, slow;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, r;
  logic [3:0]  wstrb, press, want, bl, st, sel, v;
  logic [1:0]  bresp, rresp;
  logic [5:0]  il;
  logic [33:0] e;
  logic [33:0] rd_q[$];
  logic [1:0]  b_q[$];
  logic [7:0]  fofs[3];
  int          miscompares, compares;

  pbl_panel #(.FLASH_HALF_CYC(HALF)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .button_press(press), .button_lamp_q(bl), .indicator_lamp_q(il)
  );

  pbl_pin_model keys (.aclk(aclk), .want(want), .slow(slow),
                      .button_press(press));

  // Free-running system clock
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Write: ready is read at the falling edge, so it is the value at the
  // next rising edge; the master never guesses a latency
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic a1, w1, aok, wok, b;
    aok = 1'b0;
    wok = 1'b0;
    b_q.push_back(er);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aok && wok)) begin
      @(negedge aclk);
      a1 = awready && !aok;
      w1 = wready && !wok;
      @(posedge aclk);
      if (a1) begin awvalid <= 1'b0; aok = 1'b1; end
      if (w1) begin wvalid <= 1'b0; wok = 1'b1; end
    end
    do begin @(negedge aclk); b = bvalid; @(posedge aclk); end while (!b);
    bready <= 1'b0;
    @(posedge aclk);  // Next call may raise bready only after an edge
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    logic t;
    rd_q.push_back({er, ed});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin @(negedge aclk); t = arready; @(posedge aclk); end while (!t);
    arvalid <= 1'b0;
    do begin @(negedge aclk); t = rvalid; @(posedge aclk); end while (!t);
    rready <= 1'b0;
    @(posedge aclk);  // Next call may raise rready only after an edge
  endtask

  // Watch lamps for two flash periods: steady bits, shared phase, duty
  task automatic lamp_watch(input logic ind, input logic [5:0] sv,
                            input logic [5:0] m);
    logic [5:0] l;
    int hi;
    hi = 0;
    repeat (4 * HALF) begin
      @(negedge aclk);
      l = ind ? il : {2'h0, bl};
      check(34'(l & ~m), 34'(sv));
      check(34'((l & m) === m || (l & m) === 6'h0), 34'h1);
      hi += ((l & m) !== 6'h0);
    end
    if (m !== 6'h0) check(34'(hi), 34'(2 * HALF));
    @(posedge aclk);
  endtask

  // Result watcher: a read or write answer is taken at the next edge
  always @(negedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = (rd_q.size() > 0) ? rd_q.pop_front() : 34'h3_FFFF_FFFF;
      check({rresp, (e[33:32] === OK) ? rdata : 32'h0}, e);
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      e = (b_q.size() > 0) ? {32'h0, b_q.pop_front()} : 34'h3;
      check({32'h0, bresp}, e);
    end
  end

  // Watchdog sized well above the expected run of under a thousand cycles
  initial begin
    cyc(30000);
    miscompares++;
    test_done();
  end

  initial begin
    fofs = '{pbl_pkg::OFS_FORCE_EQ, pbl_pkg::OFS_FORCE_OR,
             pbl_pkg::OFS_FORCE_AND};
    aresetn = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'h0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; want = 4'h0; slow = 1'b0;
    r = 32'h6892;
    cyc(6);
    aresetn <= 1'b1;
    cyc(1);
    // Reset contents, readback masks, refused and write-only places
    axi_rd(pbl_pkg::OFS_LATCH_SEL, 32'h0, OK);
    axi_rd(pbl_pkg::OFS_SEPARATE, 32'h0, OK);
    axi_rd(pbl_pkg::OFS_PRESSED, 32'h0, OK);
    for (int i = 0; i < 4; i++) begin
      r = lfsr_next(r);
      axi_wr(pbl_pkg::OFS_LATCH_SEL, r, OK);
      axi_rd(pbl_pkg::OFS_LATCH_SEL, {28'h0, r[3:0]}, OK);
      axi_wr(pbl_pkg::OFS_SEPARATE, r, OK);
      axi_rd(pbl_pkg::OFS_SEPARATE, {31'h0, r[0]}, OK);
    end
    axi_wr(8'h40, 32'hFFFF_FFFF, SE);
    axi_rd(8'h40, 32'h0, SE);
    axi_rd(pbl_pkg::OFS_BTN_ON, 32'h0, OK);
    axi_rd(pbl_pkg::OFS_IND_FLASH, 32'h0, OK);
    // Momentary buttons follow the keys, lamps follow the buttons
    axi_wr(pbl_pkg::OFS_LATCH_SEL, 32'h0, OK);
    axi_wr(pbl_pkg::OFS_SEPARATE, 32'h0, OK);
    want <= 4'h9;
    cyc(8);
    axi_rd(pbl_pkg::OFS_PRESSED, 32'h9, OK);
    lamp_watch(1'b0, 6'h09, 6'h00);
    want <= 4'h0;
    cyc(8);
    axi_rd(pbl_pkg::OFS_PRESSED, 32'h0, OK);
    // Alternate buttons toggle on each press, with a slow key
    slow <= 1'b1;
    axi_wr(pbl_pkg::OFS_LATCH_SEL, 32'hF, OK);
    for (int i = 0; i < 2; i++) begin
      want <= 4'h2;
      cyc(12);
      want <= 4'h0;
      cyc(12);
      axi_rd(pbl_pkg::OFS_PRESSED, (i == 0) ? 32'h2 : 32'h0, OK);
    end
    // Forces of all three kinds on random buttons and values
    st = 4'h0;
    for (int i = 0; i < 12; i++) begin
      r = lfsr_next(r);
      sel = r[7:4];
      v = r[3:0];
      for (int k = 0; k < 4; k++) begin
        if (sel[k]) begin
          st[k] = (i % 3 == 0) ? v[k] : (i % 3 == 1) ? (st[k] | v[k])
                : !(st[k] & v[k]);
        end
      end
      axi_wr(fofs[i % 3], {24'h0, sel, v}, OK);
      axi_rd(pbl_pkg::OFS_PRESSED, {28'h0, st}, OK);
    end
    // Host-owned button lamps: on, flash, flash without on
    slow <= 1'b0;
    axi_wr(pbl_pkg::OFS_LATCH_SEL, 32'h0, OK);
    axi_wr(pbl_pkg::OFS_SEPARATE, 32'h1, OK);
    axi_wr(pbl_pkg::OFS_BTN_ON, 32'h6, OK);
    axi_wr(pbl_pkg::OFS_BTN_FLASH, 32'h5, OK);
    cyc(4);
    lamp_watch(1'b0, 6'h02, 6'h04);
    want <= 4'h1;
    axi_wr(pbl_pkg::OFS_BTN_FLASH, 32'h0, OK);
    cyc(6);
    lamp_watch(1'b0, 6'h06, 6'h00);
    axi_wr(pbl_pkg::OFS_SEPARATE, 32'h0, OK);
    cyc(4);
    lamp_watch(1'b0, 6'h01, 6'h00);
    want <= 4'h0;
    // Indicators: steady, flashing, and flash without on
    axi_wr(pbl_pkg::OFS_IND_ON, 32'h2D, OK);
    axi_wr(pbl_pkg::OFS_IND_FLASH, 32'h15, OK);
    cyc(4);
    lamp_watch(1'b1, 6'h28, 6'h05);
    axi_wr(pbl_pkg::OFS_IND_ON, 32'h12, OK);
    cyc(4);
    lamp_watch(1'b1, 6'h02, 6'h10);
    test_done();
  end
endmodule
